// ---- hw/qei_defs.svh ----
// Register offsets, field positions and reset values of the encoder interface.
// Assumes inclusion by bare name from the design file or the bench.
`ifndef QEI_DEFS_SVH
`define QEI_DEFS_SVH
`define QEI_CTRL_ADDR     8'h00
`define QEI_STAT_ADDR     8'h04
`define QEI_POS_ADDR      8'h08
`define QEI_INIT_ADDR     8'h0C
`define QEI_IDX_ADDR      8'h10
`define QEI_VEL_ADDR      8'h14
`define QEI_GEC_ADDR      8'h18
`define QEI_LEC_ADDR      8'h1C
`define QEI_TMR_ADDR      8'h20
`define QEI_CTRL_RST      32'h0000_0000
`define QEI_CTRL_EN_BIT   0
`define QEI_CTRL_MODE_LSB 1
`define QEI_CTRL_IDXRST_BIT 4
`define QEI_CTRL_FLT_LSB  8
`define QEI_STAT_DIR_BIT  0
`define QEI_STAT_GT_BIT   1
`define QEI_STAT_LT_BIT   2
`define QEI_STAT_IDX_BIT  3
`define QEI_STAT_ERR_BIT  4
`endif

// ---- hw/qei_pkg.sv ----
// Types shared by the encoder interface.
// Uses no definitions from qei_defs.svh.
package qei_pkg;
   typedef enum logic [2:0] {
      MODE_QUAD      = 3'b000,
      MODE_TIMER     = 3'b001,
      MODE_UPDOWN    = 3'b010,
      MODE_GATED_CNT = 3'b011,
      MODE_GATED_TMR = 3'b100
   } count_mode_t;
endpackage : qei_pkg

// ---- hw/quadrature_encoder_interface.sv ----
// Quadrature encoder interface: filters, decoder, position/index/velocity counters,
// compares and interval timer. Assumes synchronous encoder inputs and a one-cycle register port.
`timescale 1ns/10ps
`include "qei_defs.svh"

// Summary of operation
// RQ1: Gray-order transitions of A,B count up or down, four per cycle.
// RQ2: Both phases changing together is invalid: no count, direction kept.
// RQ3: An unchanged phase state gives no pulse and keeps direction.
// RQ4: Pulses come only from a valid change of the two-phase state.
// RQ5: Last direction is stored until reversed and readable in status.
// RQ6: Phase, index and home inputs each pass a programmable noise filter.
// RQ7: An active index pulse can reload the position counter.
// RQ8: Index pulses are counted in their own 32-bit counter.
// RQ9: Greater and less thresholds are compared with the position count.
// RQ10: Decoder and compare events raise the interrupt request.
// RQ11: A mode runs the counter as a plain timer.
// RQ12: External up/down mode: A gives pulses, B gives direction.
// RQ13: Gated count mode counts A pulses only while home gate is high.
// RQ14: Gated timer mode counts clocks while home gate is high.
// RQ15: Counter steps by one either way and wraps modulo 2^32.
module quadrature_encoder_interface #(
   parameter int FLT_W = 4
) (
   input  wire logic        clk_i,
   input  wire logic        srst_i,
   input  wire logic        phase_a_input_i,
   input  wire logic        phase_b_input_i,
   input  wire logic        index_pulse_input_i,
   input  wire logic        home_pulse_input_i,
   input  wire logic [7:0]  addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [31:0] rdata_o,
   output logic             irq_o
);
   // ****************************************************************
   // Registers
   // ****************************************************************
   logic [31:0] ctrl_reg, init_reg, pos_reg, idx_reg, vel_reg, gec_reg, lec_reg, tmr_reg;
   logic [31:0] pos_next;
   logic [4:0]  stat_reg;
   logic [4:0]  stat_next;
   logic [3:0]  raw_reg;
   logic [3:0]  flt_reg;
   logic [FLT_W-1:0] fcnt_reg [4];
   logic        phase_a_state, phase_b_state;
   logic        prev_a_reg, prev_b_reg, prev_idx_reg, dir_reg;
   logic [31:0] rdata_next;

   wire         enable     = ctrl_reg[`QEI_CTRL_EN_BIT];
   qei_pkg::count_mode_t mode;
   assign mode = qei_pkg::count_mode_t'(ctrl_reg[`QEI_CTRL_MODE_LSB +: 3]);
   wire         idx_reset  = ctrl_reg[`QEI_CTRL_IDXRST_BIT];
   wire [FLT_W-1:0] flt_len = ctrl_reg[`QEI_CTRL_FLT_LSB +: FLT_W];
   wire [3:0]   pins       = {home_pulse_input_i, index_pulse_input_i, phase_b_input_i, phase_a_input_i};

   // ****************************************************************
   // Noise filters
   // ****************************************************************
   // RQ6 per-input filter
   // Output follows an input only after it has held a new level flt_len+1 clocks; 0 passes through.
   always_ff @(posedge clk_i) begin
      raw_reg <= srst_i ? 4'h0 : pins;
      for (int i = 0; i < 4; i++) begin
         if (srst_i) begin
            fcnt_reg[i] <= '0;
            flt_reg[i]  <= 1'b0;
         end else if (raw_reg[i] == flt_reg[i]) begin
            fcnt_reg[i] <= '0;
         end else if (fcnt_reg[i] >= flt_len) begin
            fcnt_reg[i] <= '0;
            flt_reg[i]  <= raw_reg[i];
         end else begin
            fcnt_reg[i] <= fcnt_reg[i] + 1'b1;
         end
      end
   end

   assign phase_a_state = flt_reg[0];
   assign phase_b_state = flt_reg[1];
   wire   index_f = flt_reg[2];
   wire   home_f  = flt_reg[3];

   // ****************************************************************
   // Decoder
   // ****************************************************************
   wire a_chg = phase_a_state ^ prev_a_reg;
   wire b_chg = phase_b_state ^ prev_b_reg;
   // RQ2 both changed
   wire invalid = a_chg & b_chg;
   // RQ3 RQ4 single-phase change only
   wire q_step = a_chg ^ b_chg;
   // RQ1 up when new A differs from old B
   wire q_up = phase_a_state ^ prev_b_reg;
   wire a_rise = phase_a_state & ~prev_a_reg;
   wire idx_rise = index_f & ~prev_idx_reg;

   logic step, up;
   always_comb begin
      step = 1'b0;
      up   = dir_reg;
      case (mode)
         qei_pkg::MODE_QUAD: begin
            step = q_step;
            up   = q_step ? q_up : dir_reg;
         end
         // RQ11 free timer
         qei_pkg::MODE_TIMER: begin
            step = 1'b1;
            up   = 1'b1;
         end
         // RQ12 B is direction
         qei_pkg::MODE_UPDOWN: begin
            step = a_rise;
            up   = phase_b_state;
         end
         // RQ13 gated pulses
         qei_pkg::MODE_GATED_CNT: begin
            step = a_rise & home_f;
            up   = 1'b1;
         end
         // RQ14 gated clocks
         qei_pkg::MODE_GATED_TMR: begin
            step = home_f;
            up   = 1'b1;
         end
         default: begin
            step = 1'b0;
            up   = dir_reg;
         end
      endcase
      step = step & enable;
   end

   // RQ15 wrapping step
   always_comb begin
      pos_next = pos_reg;
      if (enable && idx_reset && idx_rise && mode == qei_pkg::MODE_QUAD) begin
         // RQ7 index reload
         pos_next = init_reg;
      end else if (step) begin
         pos_next = up ? pos_reg + 32'h0000_0001 : pos_reg - 32'h0000_0001;
      end
   end

   // RQ9 threshold compares
   wire gt_hit = $signed(pos_reg) > $signed(gec_reg);
   wire lt_hit = $signed(pos_reg) < $signed(lec_reg);

   // RQ10 sticky event flags; a new event wins over the clear
   always_comb begin
      stat_next = stat_reg & ~(wr_i && addr_i == `QEI_STAT_ADDR ? wdata_i[4:0] : 5'h00);
      stat_next[`QEI_STAT_DIR_BIT] = dir_reg;
      if (gt_hit) stat_next[`QEI_STAT_GT_BIT] = 1'b1;
      if (lt_hit) stat_next[`QEI_STAT_LT_BIT] = 1'b1;
      if (enable && idx_rise) stat_next[`QEI_STAT_IDX_BIT] = 1'b1;
      if (enable && invalid && mode == qei_pkg::MODE_QUAD) stat_next[`QEI_STAT_ERR_BIT] = 1'b1;
   end

   // ****************************************************************
   // Counters
   // ****************************************************************
   wire wr_ctrl = wr_i && addr_i == `QEI_CTRL_ADDR;
   wire wr_pos  = wr_i && addr_i == `QEI_POS_ADDR;
   wire wr_init = wr_i && addr_i == `QEI_INIT_ADDR;
   wire wr_idx  = wr_i && addr_i == `QEI_IDX_ADDR;
   wire wr_gec  = wr_i && addr_i == `QEI_GEC_ADDR;
   wire wr_lec  = wr_i && addr_i == `QEI_LEC_ADDR;
   wire rd_vel  = rd_i && addr_i == `QEI_VEL_ADDR;
   wire rd_tmr  = rd_i && addr_i == `QEI_TMR_ADDR;

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         ctrl_reg     <= `QEI_CTRL_RST;
         init_reg     <= 32'h0000_0000;
         pos_reg      <= 32'h0000_0000;
         idx_reg      <= 32'h0000_0000;
         vel_reg      <= 32'h0000_0000;
         gec_reg      <= 32'h0000_0000;
         lec_reg      <= 32'h0000_0000;
         tmr_reg      <= 32'h0000_0000;
         stat_reg     <= 5'h00;
         prev_a_reg   <= 1'b0;
         prev_b_reg   <= 1'b0;
         prev_idx_reg <= 1'b0;
         dir_reg      <= 1'b0;
      end else begin
         prev_a_reg   <= phase_a_state;
         prev_b_reg   <= phase_b_state;
         prev_idx_reg <= index_f;
         stat_reg     <= stat_next;
         if (wr_ctrl) ctrl_reg <= wdata_i;
         if (wr_init) init_reg <= wdata_i;
         if (wr_gec) gec_reg <= wdata_i;
         if (wr_lec) lec_reg <= wdata_i;
         pos_reg <= wr_pos ? wdata_i : pos_next;
         // RQ5 direction held until reversed
         if (step) dir_reg <= up;
         // RQ8 index counter
         if (wr_idx) idx_reg <= wdata_i;
         else if (enable && idx_rise) idx_reg <= dir_reg ? idx_reg + 32'h0000_0001 : idx_reg - 32'h0000_0001;
         // Velocity and interval timer clear on read so software sees deltas between reads
         if (rd_vel) vel_reg <= 32'h0000_0000;
         else if (step) vel_reg <= up ? vel_reg + 32'h0000_0001 : vel_reg - 32'h0000_0001;
         if (rd_tmr) tmr_reg <= 32'h0000_0000;
         else if (enable) tmr_reg <= tmr_reg + 32'h0000_0001;
      end
   end

   // ****************************************************************
   // Register read port
   // ****************************************************************
   always_comb begin
      if (addr_i == `QEI_CTRL_ADDR) rdata_next = ctrl_reg;
      else if (addr_i == `QEI_STAT_ADDR) rdata_next = {27'h0, stat_reg};
      else if (addr_i == `QEI_POS_ADDR) rdata_next = pos_reg;
      else if (addr_i == `QEI_INIT_ADDR) rdata_next = init_reg;
      else if (addr_i == `QEI_IDX_ADDR) rdata_next = idx_reg;
      else if (addr_i == `QEI_VEL_ADDR) rdata_next = vel_reg;
      else if (addr_i == `QEI_GEC_ADDR) rdata_next = gec_reg;
      else if (addr_i == `QEI_LEC_ADDR) rdata_next = lec_reg;
      else if (addr_i == `QEI_TMR_ADDR) rdata_next = tmr_reg;
      else rdata_next = 32'h0000_0000;
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         rdata_o <= 32'h0000_0000;
         irq_o   <= 1'b0;
      end else begin
         rdata_o <= rd_i ? rdata_next : 32'h0000_0000;
         // RQ10 request from any sticky event
         irq_o   <= |stat_reg[4:1];
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   a_invalid_no_count: assert property (@(posedge clk_i) disable iff (srst_i) // RQ2
      (mode == qei_pkg::MODE_QUAD && invalid && !wr_pos && !idx_rise) |=> (pos_reg == $past(pos_reg)))
      else $error("count changed on invalid transition");
   a_idle_keeps_dir: assert property (@(posedge clk_i) disable iff (srst_i) // RQ3
      (mode == qei_pkg::MODE_QUAD && !a_chg && !b_chg) |=> (dir_reg == $past(dir_reg)))
      else $error("direction changed without transition");
   a_quad_up_step: assert property (@(posedge clk_i) disable iff (srst_i) // RQ1
      (enable && mode == qei_pkg::MODE_QUAD && q_step && q_up && !wr_pos && !idx_rise)
      |=> (pos_reg == $past(pos_reg) + 32'h0000_0001))
      else $error("valid up transition did not increment");
   a_quad_dn_step: assert property (@(posedge clk_i) disable iff (srst_i) // RQ15
      (enable && mode == qei_pkg::MODE_QUAD && q_step && !q_up && !wr_pos && !idx_rise)
      |=> (pos_reg == $past(pos_reg) - 32'h0000_0001))
      else $error("valid down transition did not decrement");
   a_pulse_only_valid: assert property (@(posedge clk_i) disable iff (srst_i) // RQ4
      (mode == qei_pkg::MODE_QUAD && step) |-> (a_chg != b_chg))
      else $error("pulse without single-phase change");
   a_dir_in_status: assert property (@(posedge clk_i) disable iff (srst_i) // RQ5
      1'b1 |=> (stat_reg[`QEI_STAT_DIR_BIT] == $past(dir_reg)))
      else $error("status direction stale");
   a_index_reload: assert property (@(posedge clk_i) disable iff (srst_i) // RQ7
      (enable && idx_reset && idx_rise && mode == qei_pkg::MODE_QUAD && !wr_pos) |=> (pos_reg == $past(init_reg)))
      else $error("index did not reload position");
   a_index_count: assert property (@(posedge clk_i) disable iff (srst_i) // RQ8
      (enable && idx_rise && !wr_idx) |=> (idx_reg != $past(idx_reg)))
      else $error("index pulse not counted");
   a_gt_flag: assert property (@(posedge clk_i) disable iff (srst_i) // RQ9
      gt_hit |=> stat_reg[`QEI_STAT_GT_BIT] ##1 irq_o)
      else $error("greater compare not flagged");
   a_gated_timer: assert property (@(posedge clk_i) disable iff (srst_i) // RQ14
      (enable && mode == qei_pkg::MODE_GATED_TMR && !home_f && !wr_pos) |=> $stable(pos_reg))
      else $error("gated timer counted while gate low");
   // Count checks skip cycles with a position write, since the write overrides any step
   a_invalid_flag: assert property (@(posedge clk_i) disable iff (srst_i) // RQ2
      (enable && invalid && mode == qei_pkg::MODE_QUAD) |=> stat_reg[`QEI_STAT_ERR_BIT])
      else $error("invalid transition not flagged");
   a_filter_hold: assert property (@(posedge clk_i) disable iff (srst_i) // RQ6
      (raw_reg[0] != flt_reg[0] && fcnt_reg[0] < flt_len) |=> $stable(flt_reg[0]))
      else $error("filter passed a short pulse");
   a_filter_pass: assert property (@(posedge clk_i) disable iff (srst_i) // RQ6
      (raw_reg[0] != flt_reg[0] && fcnt_reg[0] >= flt_len) |=> (flt_reg[0] == $past(raw_reg[0])))
      else $error("filter did not follow a held level");
   a_lt_flag: assert property (@(posedge clk_i) disable iff (srst_i) // RQ9
      lt_hit |=> stat_reg[`QEI_STAT_LT_BIT])
      else $error("less compare not flagged");
   wire any_flag = |stat_reg[4:1];
   a_irq_follows: assert property (@(posedge clk_i) disable iff (srst_i) // RQ10
      1'b1 |=> (irq_o == $past(any_flag)))
      else $error("request does not follow event flags");
   a_timer_step: assert property (@(posedge clk_i) disable iff (srst_i) // RQ11
      (enable && mode == qei_pkg::MODE_TIMER && !wr_pos)
      |=> (pos_reg == $past(pos_reg) + 32'h0000_0001))
      else $error("timer mode did not count");
   a_updown_step: assert property (@(posedge clk_i) disable iff (srst_i) // RQ12
      (enable && mode == qei_pkg::MODE_UPDOWN && a_rise && !phase_b_state && !wr_pos)
      |=> (pos_reg == $past(pos_reg) - 32'h0000_0001))
      else $error("external down pulse did not decrement");
   a_gated_cnt_hold: assert property (@(posedge clk_i) disable iff (srst_i) // RQ13
      (enable && mode == qei_pkg::MODE_GATED_CNT && !home_f && !wr_pos) |=> $stable(pos_reg))
      else $error("gated count moved while gate low");
endmodule : quadrature_encoder_interface

// ---- verification/encoder_model.sv ----
// Behavioural incremental encoder: two phases, index and home lines.
// Assumes its tasks are called from one bench process and clk_i is the block clock.
`timescale 1ns/10ps
module encoder_model (
   input  wire logic clk_i,
   output logic      phase_a_o,
   output logic      phase_b_o,
   output logic      index_o,
   output logic      home_o
);
   initial begin
      phase_a_o = 1'b0;
      phase_b_o = 1'b0;
      index_o   = 1'b0;
      home_o    = 1'b0;
   end
   // Held six edges so the shortest filter and decoder settle
   task automatic drive(input logic a, input logic b, input logic i, input logic h);
      @(posedge clk_i);
      phase_a_o <= a;
      phase_b_o <= b;
      index_o   <= i;
      home_o    <= h;
      repeat (6) @(posedge clk_i);
   endtask : drive
   task automatic step(input logic up);
      if (up) begin
         drive(~phase_b_o, phase_a_o, index_o, home_o);
      end else begin
         drive(phase_b_o, ~phase_a_o, index_o, home_o);
      end
   endtask : step
   task automatic glitch_a(input int n);
      @(posedge clk_i);
      phase_a_o <= ~phase_a_o;
      repeat (n) @(posedge clk_i);
      phase_a_o <= ~phase_a_o;
      repeat (6) @(posedge clk_i);
   endtask : glitch_a
endmodule : encoder_model

// ---- verification/tb_quadrature_encoder_interface.sv ----
// Self-checking bench for the encoder interface.
// Assumes qei_defs.svh on the include path and the encoder model beside it.
`timescale 1ns/10ps
`include "qei_defs.svh"
module tb_quadrature_encoder_interface;
   logic        clk_i  = 1'b0;
   logic        srst_i = 1'b1;
   logic [7:0]  addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0;
   logic        wr_i = 1'b0;
   logic        rd_i = 1'b0;
   logic [31:0] rdata_o;
   logic        irq_o;
   logic        pa, pb, idx, home;
   int          n_fail = 0;
   int          checks_done = 0;
   always #25 clk_i = ~clk_i;
   quadrature_encoder_interface u_quadrature_encoder_interface (
      .clk_i(clk_i), .srst_i(srst_i), .phase_a_input_i(pa), .phase_b_input_i(pb),
      .index_pulse_input_i(idx), .home_pulse_input_i(home), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));
   encoder_model u_encoder_model (
      .clk_i(clk_i), .phase_a_o(pa), .phase_b_o(pb), .index_o(idx), .home_o(home));
   // ****************
   // Bus and checks
   // ****************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge clk_i);
      wr_i    <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clk_i);
      rd_i   <= 1'b0;
      #1;
      d = rdata_o;
   endtask : rd
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      rd(a, d);
      check(d, exp);
   endtask : rdc
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : conclude
   // ****************
   // Scenarios
   // ****************
   task automatic t_quad();
      rdc(`QEI_POS_ADDR, 32'h0);
      rdc(8'hFC, 32'h0);
      // Greater threshold at the top so the flag stays quiet while status is checked
      wr(`QEI_GEC_ADDR, 32'h7FFF_FFFF);
      wr(`QEI_CTRL_ADDR, 32'h0000_0001);
      repeat (4) u_encoder_model.step(1'b1);
      rdc(`QEI_POS_ADDR, 32'h0000_0004);
      rdc(`QEI_STAT_ADDR, 32'h0000_0001);
      u_encoder_model.step(1'b0);
      rdc(`QEI_POS_ADDR, 32'h0000_0003);
      u_encoder_model.drive(~pa, ~pb, 1'b0, 1'b0);
      rdc(`QEI_POS_ADDR, 32'h0000_0003);
      rdc(`QEI_STAT_ADDR, 32'h0000_0010);
      check({31'h0, irq_o}, 32'h1);
      wr(`QEI_STAT_ADDR, 32'h0000_001F);
      repeat (10) @(posedge clk_i);
      rdc(`QEI_POS_ADDR, 32'h0000_0003);
      check({31'h0, irq_o}, 32'h0);
      $display("test quad done");
   endtask : t_quad
   task automatic t_wrap_cmp();
      wr(`QEI_POS_ADDR, 32'h0);
      u_encoder_model.step(1'b0);
      rdc(`QEI_POS_ADDR, 32'hFFFF_FFFF);
      u_encoder_model.step(1'b1);
      rdc(`QEI_POS_ADDR, 32'h0);
      wr(`QEI_GEC_ADDR, 32'h0000_0002);
      wr(`QEI_LEC_ADDR, 32'hFFFF_FFF0);
      wr(`QEI_STAT_ADDR, 32'h0000_001F);
      repeat (3) u_encoder_model.step(1'b1);
      rdc(`QEI_STAT_ADDR, 32'h0000_0003);
      check({31'h0, irq_o}, 32'h1);
      $display("test wrap and compare done");
   endtask : t_wrap_cmp
   task automatic t_index();
      wr(`QEI_INIT_ADDR, 32'h0000_0100);
      wr(`QEI_CTRL_ADDR, 32'h0000_0011);
      u_encoder_model.drive(pa, pb, 1'b1, 1'b0);
      u_encoder_model.drive(pa, pb, 1'b0, 1'b0);
      rdc(`QEI_POS_ADDR, 32'h0000_0100);
      rdc(`QEI_IDX_ADDR, 32'h0000_0001);
      $display("test index done");
   endtask : t_index
   task automatic t_filter();
      wr(`QEI_CTRL_ADDR, 32'h0000_0301);
      wr(`QEI_POS_ADDR, 32'h0);
      wr(`QEI_STAT_ADDR, 32'h0000_001F);
      u_encoder_model.glitch_a(2);
      rdc(`QEI_STAT_ADDR, 32'h0000_0001);
      rdc(`QEI_POS_ADDR, 32'h0);
      u_encoder_model.step(1'b1);
      rdc(`QEI_POS_ADDR, 32'h0000_0001);
      $display("test filter done");
   endtask : t_filter
   task automatic t_modes();
      logic [31:0] d0, d1;
      wr(`QEI_CTRL_ADDR, 32'h0000_0005);
      wr(`QEI_POS_ADDR, 32'h0);
      u_encoder_model.drive(1'b0, 1'b1, 1'b0, 1'b0);
      repeat (2) begin
         u_encoder_model.drive(1'b1, 1'b1, 1'b0, 1'b0);
         u_encoder_model.drive(1'b0, 1'b1, 1'b0, 1'b0);
      end
      u_encoder_model.drive(1'b1, 1'b0, 1'b0, 1'b0);
      u_encoder_model.drive(1'b0, 1'b0, 1'b0, 1'b0);
      rdc(`QEI_POS_ADDR, 32'h0000_0001);
      wr(`QEI_CTRL_ADDR, 32'h0000_0007);
      u_encoder_model.drive(1'b1, 1'b0, 1'b0, 1'b0);
      u_encoder_model.drive(1'b0, 1'b0, 1'b0, 1'b1);
      u_encoder_model.drive(1'b1, 1'b0, 1'b0, 1'b1);
      u_encoder_model.drive(1'b0, 1'b0, 1'b0, 1'b0);
      rdc(`QEI_POS_ADDR, 32'h0000_0002);
      wr(`QEI_CTRL_ADDR, 32'h0000_0009);
      rd(`QEI_POS_ADDR, d0);
      rd(`QEI_POS_ADDR, d1);
      check(d1, d0);
      u_encoder_model.drive(1'b0, 1'b0, 1'b0, 1'b1);
      rd(`QEI_POS_ADDR, d1);
      check({31'h0, d1 == d0}, 32'h0);
      wr(`QEI_CTRL_ADDR, 32'h0000_0003);
      rd(`QEI_POS_ADDR, d0);
      rd(`QEI_POS_ADDR, d1);
      check({31'h0, d1 == d0}, 32'h0);
      $display("test modes done");
   endtask : t_modes
   // Watchdog ends a hung run as a mismatch
   initial begin
      repeat (20000) @(posedge clk_i);
      n_fail++;
      conclude();
   end
   initial begin
      repeat (6) @(posedge clk_i);
      srst_i <= 1'b0;
      t_quad();
      t_wrap_cmp();
      t_index();
      t_filter();
      t_modes();
      conclude();
   end
endmodule : tb_quadrature_encoder_interface
